// ===== verilog/fer_readout_map.vh
// Register offsets, reset values and scaling constants of the readout bank
`ifndef FER_READOUT_MAP_VH
`define FER_READOUT_MAP_VH

// ----------------------------------------------------------------
// Register offsets (register index, byte address is four times it)
// ----------------------------------------------------------------
`define FER_IDX_INIT_POS_ANGLE 12'h71a
`define FER_IDX_D_BEMF         12'h75c
`define FER_IDX_Q_BEMF         12'h75e
`define FER_IDX_VELOCITY       12'h76e
`define FER_IDX_ROTOR_ANGLE    12'h774
`define FER_IDX_UPDATE_COUNT   12'h7f0

// ----------------------------------------------------------------
// Widths and reset values
// ----------------------------------------------------------------
`define FER_ADDR_W             14
`define FER_DATA_W             32
`define FER_RESET_VALUE        32'h00000000
`define FER_UNMAPPED_VALUE     32'h00000000

// ----------------------------------------------------------------
// Fixed-point scaling: value = raw / 2^27 * full scale
// ----------------------------------------------------------------
`define FER_FRAC_BITS          27
`define FER_ANGLE_FULL_SCALE   360
`define FER_BEMF_FULL_SCALE    60

`endif

// ===== verilog/fer_value_reg.v
// One read-only estimator result register with reset to zero
`timescale 1ns/1ps
`include "fer_readout_map.vh"

module fer_value_reg #(
  parameter WIDTH = 32
) (
  // Clock and reset
  input  wire             clk_sys,
  input  wire             rst,
  // Update from the estimator core
  input  wire             load,
  input  wire [WIDTH-1:0] value,
  // Held value
  output wire [WIDTH-1:0] held
);

  reg [WIDTH-1:0] held_q;

  always @(posedge clk_sys) begin
    if (rst) begin
      held_q <= `FER_RESET_VALUE;
    end else if (load) begin
      held_q <= value;
    end
  end

  assign held = held_q;

endmodule // fer_value_reg

// ===== verilog/fer_readout_regs.v
// Estimator readout register bank with plain register port
//
// Our own choice: the strobed register port.
`timescale 1ns/1ps
`include "fer_readout_map.vh"

// What this block does
// [R01] Initial position angle: signed, raw/2^27*360 degrees
// [R02] D-axis back-EMF: signed, raw/2^27*60/sqrt3 volts
// [R03] Q-axis back-EMF: same signed scaling as d-axis
// [R04] Velocity: signed, raw/2^27 times full-scale speed
// [R05] Rotor angle signed, reader takes modulo 360
// [R06] Readouts sit at fixed printed offsets
// [R07] All readouts zero after reset, read-only
// [R08] Each read returns one coherent 32-bit snapshot
module fer_readout_regs #(
  parameter ADDR_W = `FER_ADDR_W,
  parameter DATA_W = `FER_DATA_W
) (
  // Clock and reset
  input  wire              clk_sys,
  input  wire              rst,
  // Register port
  input  wire [ADDR_W-1:0] regAddr,
  input  wire [DATA_W-1:0] regWrData,
  input  wire              regWrStb,
  input  wire              regRdStb,
  output wire [DATA_W-1:0] regRdData,
  // Estimator core results, taken together on resultValid, except initialPositionAngle (loaded on initialPositionValid)
  input  wire              resultValid,
  input  wire [DATA_W-1:0] initialPositionAngle,
  input  wire [DATA_W-1:0] dAxisBackEmf,
  input  wire [DATA_W-1:0] qAxisBackEmf,
  input  wire [DATA_W-1:0] rotorVelocityEstimate,
  input  wire [DATA_W-1:0] rotorAngleEstimate,
  // Angle result from initial position sensing, own strobe
  input  wire              initialPositionValid
);

  // ----------------------------------------------------------------
  // Held results
  // ----------------------------------------------------------------
  wire [DATA_W-1:0] ipaHeld;
  wire [DATA_W-1:0] dEmfHeld;
  wire [DATA_W-1:0] qEmfHeld;
  wire [DATA_W-1:0] velHeld;
  wire [DATA_W-1:0] angHeld;
  reg  [DATA_W-1:0] updCount_q;
  reg  [DATA_W-1:0] rdData_q;
  reg  [DATA_W-1:0] rdData_d;
  wire [ADDR_W-1:0] regIndex;

  // Whole words load in one edge, so a read never mixes updates
  fer_value_reg #(.WIDTH(DATA_W)) uIpa ( // R01 R08
    .clk_sys (clk_sys),
    .rst     (rst),
    .load    (initialPositionValid),
    .value   (initialPositionAngle),
    .held    (ipaHeld)
  );

  fer_value_reg #(.WIDTH(DATA_W)) uDEmf ( // R02 R08
    .clk_sys (clk_sys),
    .rst     (rst),
    .load    (resultValid),
    .value   (dAxisBackEmf),
    .held    (dEmfHeld)
  );

  fer_value_reg #(.WIDTH(DATA_W)) uQEmf ( // R03 R08
    .clk_sys (clk_sys),
    .rst     (rst),
    .load    (resultValid),
    .value   (qAxisBackEmf),
    .held    (qEmfHeld)
  );

  fer_value_reg #(.WIDTH(DATA_W)) uVel ( // R04 R08
    .clk_sys (clk_sys),
    .rst     (rst),
    .load    (resultValid),
    .value   (rotorVelocityEstimate),
    .held    (velHeld)
  );

  // Raw angle kept unwrapped; readers reduce modulo 360
  fer_value_reg #(.WIDTH(DATA_W)) uAng ( // R05 R08
    .clk_sys (clk_sys),
    .rst     (rst),
    .load    (resultValid),
    .value   (rotorAngleEstimate),
    .held    (angHeld)
  );

  // ----------------------------------------------------------------
  // Update counter, shows estimator activity
  // ----------------------------------------------------------------
  always @(posedge clk_sys) begin
    if (rst) begin
      updCount_q <= `FER_RESET_VALUE; // R07
    end else if (resultValid) begin
      updCount_q <= updCount_q + {{(DATA_W-1){1'b0}}, 1'b1};
    end
  end

  // ----------------------------------------------------------------
  // Read decode; writes are ignored
  // ----------------------------------------------------------------
  assign regIndex = regAddr >> 2;

  always @* begin
    rdData_d = `FER_UNMAPPED_VALUE;
    case (regIndex[11:0])
      `FER_IDX_INIT_POS_ANGLE: rdData_d = ipaHeld; // R06
      `FER_IDX_D_BEMF:         rdData_d = dEmfHeld; // R06
      `FER_IDX_Q_BEMF:         rdData_d = qEmfHeld; // R06
      `FER_IDX_VELOCITY:       rdData_d = velHeld; // R06
      `FER_IDX_ROTOR_ANGLE:    rdData_d = angHeld; // R06
      `FER_IDX_UPDATE_COUNT:   rdData_d = updCount_q;
      default:                 rdData_d = `FER_UNMAPPED_VALUE;
    endcase
    if (regAddr[1:0] != 2'b00 ||
        regIndex[ADDR_W-1:12] != {(ADDR_W-12){1'b0}}) begin
      rdData_d = `FER_UNMAPPED_VALUE;
    end
  end

  // Read data valid only the cycle after the strobe
  always @(posedge clk_sys) begin
    if (rst) begin
      rdData_q <= `FER_RESET_VALUE; // R07
    end else if (regRdStb) begin
      rdData_q <= rdData_d;
    end else begin
      rdData_q <= `FER_RESET_VALUE;
    end
  end

  // All registers read-only: write strobe and data have no effect
  assign regRdData = rdData_q; // R07

endmodule // fer_readout_regs

// ===== testbench/fer_readout_regs_properties.sv
// Readout bank checker
`timescale 1ns/1ps
module fer_chk (
  // Watched ports
  input wire        clk_sys, rst, regWrStb, regRdStb, resultValid,
  input wire        initialPositionValid,
  input wire [13:0] regAddr,
  input wire [31:0] regRdData, initialPositionAngle, dAxisBackEmf,
  input wire [31:0] qAxisBackEmf, rotorVelocityEstimate, rotorAngleEstimate
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  property p_ipa; initialPositionValid ##1 regRdStb && regAddr==14'h1c68
    |=> regRdData==$past(initialPositionAngle,2); endproperty
  a_ipa: assert property (p_ipa) else $error("ipa");
  property p_demf; resultValid ##1 regRdStb && regAddr==14'h1d70
    |=> regRdData==$past(dAxisBackEmf,2); endproperty
  a_demf: assert property (p_demf) else $error("d-axis readout");
  property p_qemf; resultValid ##1 regRdStb && regAddr==14'h1d78
    |=> regRdData==$past(qAxisBackEmf,2); endproperty
  a_qemf: assert property (p_qemf) else $error("q-axis readout");
  property p_vel; resultValid ##1 regRdStb && regAddr==14'h1db8
    |=> regRdData==$past(rotorVelocityEstimate,2); endproperty
  a_vel: assert property (p_vel) else $error("vel");
  property p_ang; resultValid ##1 regRdStb && regAddr==14'h1dd0
    |=> regRdData==$past(rotorAngleEstimate,2); endproperty
  a_ang: assert property (p_ang) else $error("ang");
  property p_zro; $fell(rst) ##0 regRdStb |=> regRdData==0; endproperty
  a_zro: assert property (p_zro) else $error("zro");
  property p_idl; !regRdStb || regAddr[1:0]!=0 |=> regRdData==0;
  endproperty
  a_idl: assert property (p_idl) else $error("idl");
  property p_hld; regRdStb && !resultValid && regAddr==14'h1d70
    ##1 regRdStb && regAddr==14'h1d70 |=> $stable(regRdData); endproperty
  a_hld: assert property (p_hld) else $error("hld");
  c_ld: cover property (resultValid ##1 regRdStb);
  c_ip: cover property (initialPositionValid ##1 regRdStb);
  c_wr: cover property (regWrStb ##1 regRdStb);
endmodule // fer_chk
bind fer_readout_regs fer_chk u_chk (.clk_sys, .rst, .regWrStb, .regRdStb,
  .resultValid, .initialPositionValid, .regAddr, .regRdData,
  .initialPositionAngle, .dAxisBackEmf, .qAxisBackEmf,
  .rotorVelocityEstimate, .rotorAngleEstimate);

// ===== testbench/fer_readout_regs_tb.sv
// Readout bank bench
`timescale 1ns/1ps
module fer_readout_regs_tb;
  logic        clk_sys = 0, rst = 1, wr = 0, rd = 0, rv = 0, iv = 0;
  logic [13:0] a = 0;
  logic [31:0] wd = 0, q, v [5] = '{default: '0};
  logic [13:0] ad [5] = '{14'h1c68, 14'h1d70, 14'h1d78, 14'h1db8, 14'h1dd0};
  logic [31:0] b [5] = '{32'h9000_0001, 32'ha000_0002, 32'hb000_0003,
                         32'h7000_0004, 32'hf000_0005};
  int          err_count = 0, checked = 0;
  fer_readout_regs DUT (.clk_sys, .rst, .regAddr(a), .regWrData(wd),
    .regWrStb(wr), .regRdStb(rd), .regRdData(q), .resultValid(rv),
    .initialPositionAngle(v[0]), .dAxisBackEmf(v[1]), .qAxisBackEmf(v[2]),
    .rotorVelocityEstimate(v[3]), .rotorAngleEstimate(v[4]),
    .initialPositionValid(iv));
  initial forever #2 clk_sys = ~clk_sys;
  task automatic chk(input logic [31:0] e);
    checked++;
    if (q !== e) begin
      err_count++;
      $display("ERROR %0t got %h exp %h", $time, q, e);
    end
  endtask
  task automatic rdc(input logic [13:0] x, input logic [31:0] e);
    a <= x;
    rd <= 1;
    @(posedge clk_sys) rd <= 0;
    #1 chk(e);
    @(posedge clk_sys);
  endtask
  task t_rst;
    repeat (20) @(posedge clk_sys);
    rst <= 0;
    for (int i = 0; i < 5; i++) rdc(ad[i], 0);
    rdc(14'h1d71, 0);
    $display("reset done");
  endtask
  task t_ld;
    for (int i = 0; i < 5; i++) begin
      for (int j = 0; j < 5; j++) v[j] <= b[j] + i;
      rv <= 1;
      iv <= 1;
      @(posedge clk_sys) rv <= 0;
      iv <= 0;
      rdc(ad[i], b[i] + i);
    end
    $display("load done");
  endtask
  task t_wr;
    wr <= 1;
    wd <= 32'h5a5a_5a5a;
    a <= ad[1];
    @(posedge clk_sys) wr <= 0;
    rd <= 1;
    @(posedge clk_sys);
    #1 chk(b[1] + 4);
    @(posedge clk_sys) rd <= 0;
    #1 chk(b[1] + 4);
    $display("write done");
  endtask
  task t_ipv;
    @(posedge clk_sys);
    v[0] <= 32'h1234_5678;
    iv <= 1;
    @(posedge clk_sys) iv <= 0;
    rdc(ad[0], 32'h1234_5678);
    rdc(ad[1], b[1] + 4);
    rdc(14'h1fc0, 32'h0000_0005);
    $display("strobe done");
  endtask
  task t_rrs;
    rst <= 1;
    repeat (2) @(posedge clk_sys);
    rst <= 0;
    rdc(ad[1], 0);
    rdc(ad[0], 0);
    rdc(14'h1fc0, 0);
    $display("rereset done");
  endtask
  task conclude;
    $display("checked %0d errors %0d", checked, err_count);
    if (err_count == 0 && checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  initial begin
    t_rst;
    t_ld;
    t_wr;
    t_ipv;
    t_rrs;
    conclude;
  end
  initial begin
    #2000;
    err_count++;
    $display("ERROR %0t watchdog timeout", $time);
    conclude;
  end
endmodule // fer_readout_regs_tb
